// ### lapm_pkg.sv
// Purpose: shared constants, types and state layout for link power management
// Assumes: 40 MHz sys_clk, AHB-Lite register access, 32-bit words
// Notes:   one-hot link states, packed carriers for phy-facing signals
package lapm_pkg;

   // clock and timing
   localparam int unsigned CLK_MHZ        = 40;
   localparam int unsigned FTS_NS         = 16;
   localparam int unsigned L0S_IDLE_NS    = 7000;
   localparam int unsigned L1_IDLE_NS     = 32000;
   localparam int unsigned L0S_IDLE_CYC   = (L0S_IDLE_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned L1_IDLE_CYC    = (L1_IDLE_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned IDLE_W         = 11;

   // register word offsets (byte addresses)
   localparam logic [7:0] OFS_CTRL        = 8'h00;
   localparam logic [7:0] OFS_NFTS        = 8'h04;
   localparam logic [7:0] OFS_LAT         = 8'h08;
   localparam logic [7:0] OFS_CAP         = 8'h0C;
   localparam logic [7:0] OFS_STAT        = 8'h10;

   // control fields
   localparam int unsigned CTRL_L0S_EN    = 0;
   localparam int unsigned CTRL_L1_EN     = 1;
   localparam int unsigned CTRL_COMMON    = 2;
   localparam int unsigned CTRL_RETRAIN   = 3;
   localparam int unsigned CTRL_PLL_OFF   = 4;
   // nfts fields
   localparam int unsigned NFTS_COMMON_LSB = 0;
   localparam int unsigned NFTS_SEP_LSB    = 8;
   // latency fields, then capability and status layout
   localparam int unsigned LAT_L1C_LSB    = 0;
   localparam int unsigned LAT_L1S_LSB    = 3;
   localparam int unsigned LAT_L0SA_LSB   = 6;
   localparam int unsigned LAT_L1A_LSB    = 9;
   localparam int unsigned CAP_L0SX_LSB   = 0;
   localparam int unsigned CAP_L1X_LSB    = 3;
   localparam int unsigned CAP_SLOTCLK    = 6;
   localparam int unsigned CAP_L1SUP      = 7;
   localparam int unsigned CAP_L0SA_LSB   = 8;
   localparam int unsigned CAP_L1A_LSB    = 11;
   localparam int unsigned STAT_LOCK      = 8;
   localparam int unsigned STAT_TXIDLE    = 9;
   localparam int unsigned STAT_PD_LSB    = 10;

   // reset values
   localparam logic [7:0] RST_NFTS        = 8'h20;
   localparam logic [2:0] RST_L1_EXIT     = 3'h2;
   localparam logic [2:0] RST_ACCEPT      = 3'h0;

   // phy power-down encodings
   localparam logic [1:0] PD_P0           = 2'h0;
   localparam logic [1:0] PD_P0S          = 2'h1;
   localparam logic [1:0] PD_P1           = 2'h2;

   typedef enum logic [6:0] {
      LS_L0       = 7'h01,
      LS_L0S      = 7'h02,
      LS_L0S_EXIT = 7'h04,
      LS_L1_ENTRY = 7'h08,
      LS_L1       = 7'h10,
      LS_L1_EXIT  = 7'h20,
      LS_RECOVERY = 7'h40
   } lapm_lstate_t;

   typedef struct packed {
      logic txPllLock;
      logic rxElecIdle;
      logic partnerL1Ack;
      logic recoveryDone;
   } lapm_phy_in_t;

   typedef struct packed {
      logic       txElecIdle;
      logic [1:0] powerDown;
      logic       pllShutdown;
      logic       ftsSend;
      logic       l1EnterReq;
      logic       recoveryReq;
      logic       txAllowed;
   } lapm_phy_out_t;

   typedef struct packed {
      lapm_lstate_t    lstate;
      logic [IDLE_W-1:0] idleCnt;
      logic [7:0]      ftsCnt;
      logic            l0sEn;
      logic            l1En;
      logic            commonClk;
      logic            pllOffL1;
      logic            retrainPend;
      logic            activeCommon;
      logic [7:0]      nftsCommon;
      logic [7:0]      nftsSeparate;
      logic [2:0]      l1ExitCommon;
      logic [2:0]      l1ExitSeparate;
      logic [2:0]      l0sAccept;
      logic [2:0]      l1Accept;
      logic            dataHit;
      logic            dataWrite;
      logic [7:0]      dataOfs;
      logic [31:0]     hrdata;
      logic            hreadyout;
      lapm_phy_out_t   phy;
      logic [7:0]      ftsCount;
   } lapm_state_t;

   // exit latency code from fts count: 16 ns per set, power-of-two bins from 64 ns
   function automatic logic [2:0] l0s_exit_code(input logic [7:0] nfts);
      logic [12:0] ns;
      ns = 13'(nfts) * 13'(FTS_NS);
      if (ns < 13'h0040) l0s_exit_code = 3'h0;
      else if (ns < 13'h0080) l0s_exit_code = 3'h1;
      else if (ns < 13'h0100) l0s_exit_code = 3'h2;
      else if (ns < 13'h0200) l0s_exit_code = 3'h3;
      else if (ns < 13'h0400) l0s_exit_code = 3'h4;
      else if (ns < 13'h0800) l0s_exit_code = 3'h5;
      else if (ns < 13'h1000) l0s_exit_code = 3'h6;
      else l0s_exit_code = 3'h7;
   endfunction

endpackage

// ### lapm_sync.sv
// Purpose: two-flop synchroniser for phy pin inputs
// Assumes: inputs asynchronous to sys_clk
// Notes:   first stage feeds only the second
`timescale 1ns/1ps
module lapm_sync #(
   parameter int unsigned WIDTH = 4
) (
   // clock and reset
   input  wire logic             sys_clk,
   input  wire logic             rst,
   // data
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } lapm_sync_state_t;

   lapm_sync_state_t s;
   lapm_sync_state_t next_s;

   always_comb begin
      next_s        = s;
      next_s.meta   = din;
      next_s.stable = s.meta;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign dout = s.stable;

endmodule

// ### lapm_core.sv
// Purpose: active state link power management with AHB-Lite registers
// Assumes: phy pins synchronised here; txPending and linkIdle from local logic
// Notes:   zero wait state slave, response always OKAY
//
// The AHB-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ps

// What this block does
// - after enable, enters and exits low power alone
// - L0s idles transmitter only, receiver stays active
// - L1 entered jointly, no traffic until L0
// - L1 support optional, selected by parameter
// - L0s exit latency derived from fts count
// - fast training sets sent on L0s exit
// - L1 exit latency held and reported
// - phy in P1 while in L1
// - phy plls may shut down in L1
// - L1 exit waits lock, then recovery, L0
// - two exit latencies each, clock-selected
// - slot reference clock usage reported
// - acceptable latencies held, readable
// - transmit only while transmit pll locked
module lapm_core #(
   parameter int unsigned L0S_IDLE_CYC = lapm_pkg::L0S_IDLE_CYC,
   parameter int unsigned L1_IDLE_CYC  = lapm_pkg::L1_IDLE_CYC,
   parameter bit          L1_SUPPORT   = 1'b1,
   parameter bit          SLOT_CLOCK   = 1'b1
) (
   // clock and reset
   input  wire logic                   sys_clk,
   input  wire logic                   rst,
   // ahb-lite slave
   input  wire logic                   hsel,
   input  wire logic [31:0]            haddr,
   input  wire logic [1:0]             htrans,
   input  wire logic                   hwrite,
   input  wire logic [2:0]             hsize,
   input  wire logic [31:0]            hwdata,
   input  wire logic                   hready,
   output logic      [31:0]            hrdata,
   output logic                        hreadyout,
   output logic                        hresp,
   // link layer, same clock
   input  wire logic                   txPending,
   input  wire logic                   linkIdle,
   // phy pins
   input  wire lapm_pkg::lapm_phy_in_t phyIn,
   output lapm_pkg::lapm_phy_out_t     phyOut,
   output logic      [7:0]             ftsCount
);

   lapm_pkg::lapm_state_t  s;
   lapm_pkg::lapm_state_t  next_s;
   lapm_pkg::lapm_phy_in_t phySync;
   logic                   idle;
   logic                   retrainSet;
   logic                   l1Ok;
   logic                   addrOk;
   logic [7:0]             selNfts;
   logic [2:0]             selL1Exit;
   logic [31:0]            capWord;
   logic [31:0]            statWord;
   logic [31:0]            ctrlWord;

   lapm_sync #(
      .WIDTH ($bits(lapm_pkg::lapm_phy_in_t))
   ) u_sync (
      .sys_clk (sys_clk),
      .rst     (rst),
      .din     (phyIn),
      .dout    (phySync)
   );

   always_comb begin
      next_s    = s;
      idle      = linkIdle && !txPending;
      l1Ok      = L1_SUPPORT && s.l1En;
      retrainSet = s.dataHit && s.dataWrite && (s.dataOfs == lapm_pkg::OFS_CTRL) && hwdata[lapm_pkg::CTRL_RETRAIN];
      addrOk    = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);
      // latency chosen by active clock setting
      selNfts   = s.activeCommon ? s.nftsCommon : s.nftsSeparate;
      selL1Exit = s.activeCommon ? s.l1ExitCommon : s.l1ExitSeparate;
      ctrlWord  = '0;
      ctrlWord[lapm_pkg::CTRL_L0S_EN]  = s.l0sEn;
      ctrlWord[lapm_pkg::CTRL_L1_EN]   = s.l1En;
      ctrlWord[lapm_pkg::CTRL_COMMON]  = s.commonClk;
      ctrlWord[lapm_pkg::CTRL_RETRAIN] = s.retrainPend;
      ctrlWord[lapm_pkg::CTRL_PLL_OFF] = s.pllOffL1;
      capWord   = '0;
      // l0s exit latency from fts count
      capWord[lapm_pkg::CAP_L0SX_LSB +: 3] = lapm_pkg::l0s_exit_code(selNfts);
      capWord[lapm_pkg::CAP_L1X_LSB +: 3]  = selL1Exit;
      capWord[lapm_pkg::CAP_SLOTCLK]       = SLOT_CLOCK;
      capWord[lapm_pkg::CAP_L1SUP]         = L1_SUPPORT;
      capWord[lapm_pkg::CAP_L0SA_LSB +: 3] = s.l0sAccept;
      capWord[lapm_pkg::CAP_L1A_LSB +: 3]  = s.l1Accept;
      statWord  = '0;
      statWord[6:0]                        = s.lstate;
      statWord[lapm_pkg::STAT_LOCK]        = phySync.txPllLock;
      statWord[lapm_pkg::STAT_TXIDLE]      = s.phy.txElecIdle;
      statWord[lapm_pkg::STAT_PD_LSB +: 2] = s.phy.powerDown;

      // data phase of a write
      if (s.dataHit && s.dataWrite) begin
         unique case (s.dataOfs)
            lapm_pkg::OFS_CTRL: begin
               next_s.l0sEn     = hwdata[lapm_pkg::CTRL_L0S_EN];
               next_s.l1En      = hwdata[lapm_pkg::CTRL_L1_EN];
               next_s.commonClk = hwdata[lapm_pkg::CTRL_COMMON];
               next_s.pllOffL1  = hwdata[lapm_pkg::CTRL_PLL_OFF];
               if (hwdata[lapm_pkg::CTRL_RETRAIN]) begin
                  next_s.retrainPend = 1'b1;
               end
            end
            lapm_pkg::OFS_NFTS: begin
               next_s.nftsCommon   = hwdata[lapm_pkg::NFTS_COMMON_LSB +: 8];
               next_s.nftsSeparate = hwdata[lapm_pkg::NFTS_SEP_LSB +: 8];
            end
            lapm_pkg::OFS_LAT: begin
               next_s.l1ExitCommon   = hwdata[lapm_pkg::LAT_L1C_LSB +: 3];
               next_s.l1ExitSeparate = hwdata[lapm_pkg::LAT_L1S_LSB +: 3];
               next_s.l0sAccept      = hwdata[lapm_pkg::LAT_L0SA_LSB +: 3];
               next_s.l1Accept       = hwdata[lapm_pkg::LAT_L1A_LSB +: 3];
            end
            default: begin
            end
         endcase
      end

      // address phase
      next_s.dataHit   = 1'b0;
      next_s.hreadyout = 1'b1;
      if (hsel && hready && htrans[1]) begin
         next_s.dataHit   = addrOk;
         next_s.dataWrite = hwrite;
         next_s.dataOfs   = haddr[7:0];
         if (!hwrite) begin
            next_s.hrdata = '0;
            if (addrOk) begin
               unique case (haddr[7:0])
                  lapm_pkg::OFS_CTRL: next_s.hrdata = ctrlWord;
                  lapm_pkg::OFS_NFTS: next_s.hrdata = {16'h0000, s.nftsSeparate, s.nftsCommon};
                  lapm_pkg::OFS_LAT:  next_s.hrdata = {20'h00000, s.l1Accept, s.l0sAccept,
                                                       s.l1ExitSeparate, s.l1ExitCommon};
                  lapm_pkg::OFS_CAP:  next_s.hrdata = capWord;
                  lapm_pkg::OFS_STAT: next_s.hrdata = statWord;
                  default:            next_s.hrdata = '0;
               endcase
            end
         end
      end

      if (idle && (s.lstate == lapm_pkg::LS_L0 || s.lstate == lapm_pkg::LS_L0S)) begin
         if (s.idleCnt != {lapm_pkg::IDLE_W{1'b1}}) begin
            next_s.idleCnt = s.idleCnt + 1'b1;
         end
      end else begin
         next_s.idleCnt = '0;
      end

      unique case (s.lstate)
         lapm_pkg::LS_L0: begin
            if (s.retrainPend) begin
               // retrain refreshes reported latencies
               // software set in the same cycle wins over the clear
               next_s.retrainPend  = retrainSet;
               next_s.activeCommon = s.commonClk;
               next_s.lstate       = lapm_pkg::LS_RECOVERY;
            end else if (l1Ok && s.idleCnt >= lapm_pkg::IDLE_W'(L1_IDLE_CYC)) begin
               next_s.lstate = lapm_pkg::LS_L1_ENTRY;
            end else if (s.l0sEn && s.idleCnt >= lapm_pkg::IDLE_W'(L0S_IDLE_CYC)) begin
               next_s.lstate = lapm_pkg::LS_L0S;
            end
         end
         lapm_pkg::LS_L0S: begin
            if (txPending || !s.l0sEn) begin
               next_s.ftsCnt = '0;
               next_s.lstate = lapm_pkg::LS_L0S_EXIT;
            end else if (l1Ok && s.idleCnt >= lapm_pkg::IDLE_W'(L1_IDLE_CYC)) begin
               next_s.lstate = lapm_pkg::LS_L1_ENTRY;
            end
         end
         lapm_pkg::LS_L0S_EXIT: begin
            if (phySync.txPllLock) begin
               if (s.ftsCnt + 8'h01 >= s.ftsCount || s.ftsCount == 8'h00) begin
                  next_s.lstate = lapm_pkg::LS_L0;
               end
               next_s.ftsCnt = s.ftsCnt + 8'h01;
            end
         end
         lapm_pkg::LS_L1_ENTRY: begin
            if (phySync.partnerL1Ack) begin
               next_s.lstate = lapm_pkg::LS_L1;
            end else if (txPending) begin
               next_s.lstate = lapm_pkg::LS_L0;
            end
         end
         lapm_pkg::LS_L1: begin
            if (txPending || !phySync.rxElecIdle || !l1Ok) begin
               next_s.lstate = lapm_pkg::LS_L1_EXIT;
            end
         end
         lapm_pkg::LS_L1_EXIT: begin
            if (phySync.txPllLock) begin
               next_s.lstate = lapm_pkg::LS_RECOVERY;
            end
         end
         lapm_pkg::LS_RECOVERY: begin
            if (phySync.recoveryDone) begin
               next_s.lstate = lapm_pkg::LS_L0;
            end
         end
         default: begin
            next_s.lstate = lapm_pkg::LS_L0;
         end
      endcase

      // phy control follows the next state
      next_s.ftsCount        = selNfts;
      next_s.phy.txElecIdle  = (next_s.lstate == lapm_pkg::LS_L0S) ||
                               (next_s.lstate == lapm_pkg::LS_L1) ||
                               (next_s.lstate == lapm_pkg::LS_L1_EXIT);
      next_s.phy.powerDown   = lapm_pkg::PD_P0;
      if (next_s.lstate == lapm_pkg::LS_L0S) begin
         next_s.phy.powerDown = lapm_pkg::PD_P0S;
      end
      if (next_s.lstate == lapm_pkg::LS_L1) begin
         next_s.phy.powerDown = lapm_pkg::PD_P1;
      end
      next_s.phy.pllShutdown = (next_s.lstate == lapm_pkg::LS_L1) && s.pllOffL1;
      next_s.phy.ftsSend     = (next_s.lstate == lapm_pkg::LS_L0S_EXIT) && phySync.txPllLock;
      next_s.phy.l1EnterReq  = (next_s.lstate == lapm_pkg::LS_L1_ENTRY);
      next_s.phy.recoveryReq = (next_s.lstate == lapm_pkg::LS_RECOVERY);
      // traffic only in L0 with lock
      next_s.phy.txAllowed   = (next_s.lstate == lapm_pkg::LS_L0) && phySync.txPllLock;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s                <= '0;
         s.lstate         <= lapm_pkg::LS_L0;
         s.nftsCommon     <= lapm_pkg::RST_NFTS;
         s.nftsSeparate   <= lapm_pkg::RST_NFTS;
         s.l1ExitCommon   <= lapm_pkg::RST_L1_EXIT;
         s.l1ExitSeparate <= lapm_pkg::RST_L1_EXIT;
         s.l0sAccept      <= lapm_pkg::RST_ACCEPT;
         s.l1Accept       <= lapm_pkg::RST_ACCEPT;
         s.hreadyout      <= 1'b1;
         s.ftsCount       <= lapm_pkg::RST_NFTS;
      end else begin
         s <= next_s;
      end
   end

   assign hrdata    = s.hrdata;
   assign hreadyout = s.hreadyout;
   assign hresp     = 1'b0;
   assign phyOut    = s.phy;
   assign ftsCount  = s.ftsCount;

endmodule

// ### lapm_core_monitor.sv
// Purpose: port assertions for lapm_core
// Assumes: one sys_clk domain, rst async active high
// Notes: bound to every lapm_core
`timescale 1ns/1ps
module lapm_core_monitor #(
   parameter int unsigned L0S_IDLE_CYC = 4,
   parameter int unsigned L1_IDLE_CYC  = 12,
   parameter bit          L1_SUPPORT   = 1'b1,
   parameter bit          SLOT_CLOCK   = 1'b1
) (
   // clock and reset
   input wire logic                    sys_clk,
   input wire logic                    rst,
   // ahb-lite
   input wire logic                    hsel,
   input wire logic [31:0]             haddr,
   input wire logic [1:0]              htrans,
   input wire logic                    hwrite,
   input wire logic [2:0]              hsize,
   input wire logic [31:0]             hwdata,
   input wire logic                    hready,
   input wire logic [31:0]             hrdata,
   input wire logic                    hreadyout,
   input wire logic                    hresp,
   // link and phy
   input wire logic                    txPending,
   input wire logic                    linkIdle,
   input wire lapm_pkg::lapm_phy_in_t  phyIn,
   input wire lapm_pkg::lapm_phy_out_t phyOut,
   input wire logic [7:0]              ftsCount
);
   logic [15:0] idleRun;
   logic [8:0]  ftsRun;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   // idle and fts run lengths
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         idleRun <= 16'h0000;
         ftsRun  <= 9'h000;
      end else begin
         idleRun <= (linkIdle && !txPending) ? idleRun + 16'h0001 : 16'h0000;
         ftsRun  <= phyOut.ftsSend ? ftsRun + 9'h001 : 9'h000;
      end
   end

   sequence s_l0s_wake;
      phyOut.powerDown == lapm_pkg::PD_P0S && txPending;
   endsequence
   sequence s_rec_end;
      phyOut.recoveryReq ##1 !phyOut.recoveryReq;
   endsequence

   a_tx_when_locked: assert property (phyOut.txAllowed |-> $past(phyIn.txPllLock, 3))
      else $error("transmit allowed without pll lock");
   a_tx_only_l0: assert property (phyOut.txAllowed |-> !phyOut.txElecIdle && phyOut.powerDown == 2'h0)
      else $error("transmit allowed outside L0");
   a_l0s_rx_only: assert property (phyOut.powerDown == lapm_pkg::PD_P0S |-> phyOut.txElecIdle)
      else $error("L0s without transmit idle");
   a_l1_phy_p1: assert property (phyOut.powerDown == 2'h2 |-> L1_SUPPORT && phyOut.txElecIdle && !phyOut.ftsSend)
      else $error("bad outputs in L1");
   a_pll_off_l1: assert property (phyOut.pllShutdown |-> phyOut.powerDown == lapm_pkg::PD_P1)
      else $error("pll shut down outside L1");
   a_fts_burst_len: assert property ($fell(phyOut.ftsSend) && phyOut.txAllowed
      |-> ftsRun == ((ftsCount == 8'h00) ? 9'h001 : {1'b0, ftsCount}))
      else $error("fts burst length wrong");
   a_l1_joint_entry: assert property ($rose(phyOut.powerDown == lapm_pkg::PD_P1)
      |-> $past(phyOut.l1EnterReq) && $past(phyIn.partnerL1Ack, 3))
      else $error("L1 entered without partner ack");
   a_recovery_done: assert property (s_rec_end |-> $past(phyIn.recoveryDone, 3))
      else $error("recovery left without completion");
   a_l0s_wake_exit: assert property (s_l0s_wake |=> !phyOut.txElecIdle && phyOut.powerDown == 2'h0)
      else $error("pending traffic did not wake L0s");
   a_l0s_idle_entry: assert property ($rose(phyOut.powerDown == 2'h1) |-> $past(idleRun) >= L0S_IDLE_CYC)
      else $error("L0s entered before idle time");
   a_bus_zero_wait: assert property (hreadyout && !hresp)
      else $error("bus wait state or error response");
endmodule

bind lapm_core lapm_core_monitor #(
   .L0S_IDLE_CYC(L0S_IDLE_CYC), .L1_IDLE_CYC(L1_IDLE_CYC), .L1_SUPPORT(L1_SUPPORT), .SLOT_CLOCK(SLOT_CLOCK)
) lapm_core_monitor_i (
   .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
   .hresp(hresp), .txPending(txPending), .linkIdle(linkIdle), .phyIn(phyIn), .phyOut(phyOut),
   .ftsCount(ftsCount)
);

// ### lapm_partner.sv
// Purpose: link partner and phy model
// Assumes: pins answer on sys_clk
// Notes: lockDelay sets pll settle and recovery time
`timescale 1ns/1ps
module lapm_partner (
   // clock and reset
   input  wire logic                    sys_clk,
   input  wire logic                    rst,
   // scenario controls
   input  wire logic                    ackEn,
   input  wire logic                    wake,
   input  wire logic [3:0]              lockDelay,
   // phy pins
   input  wire lapm_pkg::lapm_phy_out_t phyOut,
   output lapm_pkg::lapm_phy_in_t       phyIn
);
   logic [3:0] lockCnt;
   logic [3:0] recCnt;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         lockCnt <= 4'h0;
         recCnt  <= 4'h0;
      end else begin
         lockCnt <= phyOut.pllShutdown ? 4'h0 : lockCnt + {3'h0, lockCnt != 4'hF};
         recCnt  <= phyOut.recoveryReq ? recCnt + {3'h0, recCnt != 4'hF} : 4'h0;
      end
   end

   // joint L1 entry, recovery by both ends
   assign phyIn = '{txPllLock: lockCnt >= lockDelay,
                    rxElecIdle: ackEn && !wake && (phyOut.l1EnterReq || phyOut.powerDown == 2'h2),
                    partnerL1Ack: ackEn && phyOut.l1EnterReq,
                    recoveryDone: phyOut.recoveryReq && recCnt >= lockDelay};
endmodule

// ### lapm_core_test.sv
// Purpose: register and link tests for lapm_core
// Assumes: partner model on phy pins, zero wait bus
// Notes: idle counts 4 and 12 keep the run short
`timescale 1ns/1ps
module lapm_core_test;
   logic                    sys_clk;
   logic                    rst;
   logic [31:0]             haddr;
   logic [1:0]              htrans;
   logic                    hwrite;
   logic [31:0]             hwdata;
   logic [31:0]             hrdata;
   logic                    hreadyout;
   logic                    txPending;
   logic                    linkIdle;
   logic                    ackEn;
   logic                    wake;
   lapm_pkg::lapm_phy_in_t  phyIn;
   lapm_pkg::lapm_phy_out_t phyOut;
   logic [7:0]              ftsCount;
   logic [31:0]             rdata;
   int                      errorCnt;
   int                      checkCount;

   lapm_core #(.L0S_IDLE_CYC(4), .L1_IDLE_CYC(12)) lapm_core_i (
      .sys_clk(sys_clk), .rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(), .txPending(txPending), .linkIdle(linkIdle), .phyIn(phyIn), .phyOut(phyOut),
      .ftsCount(ftsCount)
   );
   lapm_partner lapm_partner_i (
      .sys_clk(sys_clk), .rst(rst), .ackEn(ackEn), .wake(wake), .lockDelay(4'hA),
      .phyOut(phyOut), .phyIn(phyIn)
   );

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   task automatic summarize();
      $display("checks %0d errors %0d", checkCount, errorCnt);
      if (errorCnt == 0 && checkCount > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checkCount++;
      if (seen !== exp) begin
         errorCnt++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // one edge with hready high
   task automatic step();
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 64);
      if (hreadyout !== 1'b1) begin
         errorCnt++;
         summarize();
      end
   endtask

   task automatic xfer(input logic wr, input logic [7:0] adr, input logic [31:0] wd);
      haddr  <= {24'h000000, adr};
      htrans <= 2'h2;
      hwrite <= wr;
      step();
      htrans <= 2'h0;
      hwdata <= wd;
      step();
      rdata = hrdata;
   endtask

   task automatic rd(input string nm, input logic [7:0] adr, input logic [31:0] exp);
      xfer(1'b0, adr, 32'h00000000);
      chk(nm, rdata, exp);
   endtask

   // poll state field of status
   task automatic wait_st(input logic [6:0] st);
      int n;
      n = 0;
      do begin
         xfer(1'b0, 8'h10, 32'h00000000);
         n++;
      end while (rdata[6:0] !== st && n < 2000);
      chk("state", {25'h0, rdata[6:0]}, {25'h0, st});
      if (rdata[6:0] !== st) summarize();
   endtask

   initial begin
      rst        = 1'b1;
      haddr      = 32'h0;
      htrans     = 2'h0;
      hwrite     = 1'b0;
      hwdata     = 32'h0;
      txPending  = 1'b0;
      linkIdle   = 1'b0;
      ackEn      = 1'b0;
      wake       = 1'b0;
      errorCnt   = 0;
      checkCount = 0;
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      rd("ctrl", 8'h00, 32'h0);
      rd("nfts", 8'h04, 32'h2020);
      rd("lat", 8'h08, 32'h12);
      rd("cap", 8'h0C, 32'hD4);
      xfer(1'b1, 8'h0C, 32'hFFFFFFFF);
      rd("cap ro", 8'h0C, 32'hD4);
      xfer(1'b1, 8'h14, 32'hFFFFFFFF);
      rd("unmapped", 8'h14, 32'h0);
      rd("stat", 8'h10, 32'h101);
      xfer(1'b1, 8'h04, 32'h0402);
      xfer(1'b1, 8'h08, 32'hF9D);
      rd("cap sep", 8'h0C, 32'h3ED9);
      chk("fts sep", {24'h0, ftsCount}, 32'h4);
      xfer(1'b1, 8'h00, 32'h0C);
      wait_st(7'h40);
      wait_st(7'h01);
      rd("ctrl", 8'h00, 32'h4);
      rd("cap com", 8'h0C, 32'h3EE8);
      chk("fts com", {24'h0, ftsCount}, 32'h2);
      xfer(1'b1, 8'h08, 32'h1D);
      rd("lat", 8'h08, 32'h1D);
      xfer(1'b1, 8'h00, 32'h05);
      linkIdle <= 1'b1;
      wait_st(7'h02);
      rd("stat l0s", 8'h10, 32'h702);
      txPending <= 1'b1;
      linkIdle  <= 1'b0;
      wait_st(7'h01);
      chk("txAllowed", {31'h0, phyOut.txAllowed}, 32'h1);
      txPending <= 1'b0;
      xfer(1'b1, 8'h00, 32'h17);
      linkIdle <= 1'b1;
      wait_st(7'h08);
      txPending <= 1'b1;
      wait_st(7'h01);
      ackEn     <= 1'b1;
      txPending <= 1'b0;
      wait_st(7'h10);
      repeat (4) @(posedge sys_clk);
      rd("stat l1", 8'h10, 32'hA10);
      chk("pll off", {31'h0, phyOut.pllShutdown}, 32'h1);
      linkIdle <= 1'b0;
      wake     <= 1'b1;
      wait_st(7'h40);
      wait_st(7'h01);
      chk("txAllowed", {31'h0, phyOut.txAllowed}, 32'h1);
      summarize();
   end
endmodule
